// ### htc_pkg.sv
// Purpose: shared constants for the hybrid tap five to eight coefficient bank
// Assumes: register index equals the port address
// Notes:   addresses are register indices, not byte addresses
`default_nettype none
package htc_pkg;
	localparam int          HTC_AW          = 8;
	localparam int          HTC_DW          = 8;
	localparam int          HTC_NTAP        = 4;
	localparam logic [7:0]  HTC_IDX_TAP5    = 8'h31;
	localparam logic [7:0]  HTC_IDX_TAP6    = 8'h32;
	localparam logic [7:0]  HTC_IDX_TAP7    = 8'h33;
	localparam logic [7:0]  HTC_IDX_TAP8    = 8'h34;
	localparam logic [7:0]  HTC_IDX_RSV_LO  = 8'h35;
	localparam logic [7:0]  HTC_IDX_RSV_HI  = 8'h3A;
	localparam logic [7:0]  HTC_COEF_RST    = 8'h00;
	localparam logic [7:0]  HTC_RD_ZERO     = 8'h00;
	localparam logic [1:0]  HTC_SEL_TAP5    = 2'h0;
	localparam logic [1:0]  HTC_SEL_TAP6    = 2'h1;
	localparam logic [1:0]  HTC_SEL_TAP7    = 2'h2;
	localparam logic [1:0]  HTC_SEL_TAP8    = 2'h3;
endpackage
`default_nettype wire

// ### htc_coef_reg.sv
// Purpose: one 8-bit coefficient register with write enable
// Assumes: srst synchronous active high
// Notes:   value feeds the filter stage directly, no shadow copy
`timescale 1ns/10ps
`default_nettype none
module htc_coef_reg
	import htc_pkg::*;
(
	input  wire logic              clk_sys,
	input  wire logic              srst,
	input  wire logic              wr_en,
	input  wire logic [HTC_DW-1:0] wr_data,
	output logic      [HTC_DW-1:0] coef
);
	logic [HTC_DW-1:0] coef_reg;
	logic [HTC_DW-1:0] coef_next;

	// load on write, otherwise hold; reset to zero keeps stage inert
	always_comb begin
		coef_next = coef_reg;
		if (srst) begin
			coef_next = HTC_COEF_RST;
		end else if (wr_en) begin
			coef_next = wr_data;
		end
	end

	always_ff @(posedge clk_sys) begin
		coef_reg <= coef_next;
	end

	assign coef = coef_reg;
endmodule
`default_nettype wire

// ### htc_regs.sv
// Purpose: register bank for hybrid filter taps five to eight
// Assumes: single clock, plain strobe bus, read data one cycle later
// Notes:   reserved indices read zero; writes there are not stored but set rsvd_wr_seen
//
// Local design decision: the address-and-strobe port.
`timescale 1ns/10ps
`default_nettype none
module htc_regs
	import htc_pkg::*;
(
	input  wire logic              clk_sys,
	input  wire logic              srst,
	input  wire logic [HTC_AW-1:0] reg_addr,
	input  wire logic [HTC_DW-1:0] reg_wdata,
	input  wire logic              reg_wr,
	input  wire logic              reg_rd,
	output logic      [HTC_DW-1:0] reg_rdata,
	output logic      [HTC_DW-1:0] tap5_coefficient,
	output logic      [HTC_DW-1:0] tap6_coefficient,
	output logic      [HTC_DW-1:0] tap7_coefficient,
	output logic      [HTC_DW-1:0] tap8_coefficient,
	output logic                   tap5_active,
	output logic                   tap6_active,
	output logic                   tap7_active,
	output logic                   tap8_active,
	output logic                   rsvd_wr_seen
);
	// ***********************************************************
	// address decode
	// ***********************************************************

	// one-hot tap select, zero for anything outside taps 5..8
	function automatic logic [HTC_NTAP-1:0] tap_hit(
		input logic [HTC_AW-1:0] a
	);
		logic [HTC_NTAP-1:0] h;
		h = '0;
		case (a)
			HTC_IDX_TAP5: h[HTC_SEL_TAP5] = 1'b1;
			HTC_IDX_TAP6: h[HTC_SEL_TAP6] = 1'b1;
			HTC_IDX_TAP7: h[HTC_SEL_TAP7] = 1'b1;
			HTC_IDX_TAP8: h[HTC_SEL_TAP8] = 1'b1;
			default:      h = '0;
		endcase
		return h;
	endfunction

	function automatic logic is_rsvd(input logic [HTC_AW-1:0] a);
		return (a >= HTC_IDX_RSV_LO) && (a <= HTC_IDX_RSV_HI);
	endfunction

	logic [HTC_NTAP-1:0] wr_hit;
	logic [HTC_DW-1:0]   coef [HTC_NTAP];

	// writes only reach decoded taps; reserved space is never stored
	assign wr_hit = reg_wr ? tap_hit(reg_addr) : '0;

	// ***********************************************************
	// coefficient storage
	// ***********************************************************

	// one register per tap, each updates on its own decoded write
	genvar gi;
	generate
		for (gi = 0; gi < HTC_NTAP; gi++) begin : g_tap
			htc_coef_reg u_coef (
				.clk_sys (clk_sys),
				.srst    (srst),
				.wr_en   (wr_hit[gi]),
				.wr_data (reg_wdata),
				.coef    (coef[gi])
			);
		end
	endgenerate

	// coefficients go straight to the filter, live from next cycle
	assign tap5_coefficient = coef[HTC_SEL_TAP5];
	assign tap6_coefficient = coef[HTC_SEL_TAP6];
	assign tap7_coefficient = coef[HTC_SEL_TAP7];
	assign tap8_coefficient = coef[HTC_SEL_TAP8];

	// stage enables: zero coefficient means no contribution
	assign tap5_active = |coef[HTC_SEL_TAP5];
	assign tap6_active = |coef[HTC_SEL_TAP6];
	assign tap7_active = |coef[HTC_SEL_TAP7];
	assign tap8_active = |coef[HTC_SEL_TAP8];

	// ***********************************************************
	// read path and reserved-write flag
	// ***********************************************************

	logic [HTC_DW-1:0] rdata_reg;
	logic [HTC_DW-1:0] rdata_next;
	logic              rsvd_reg;
	logic              rsvd_next;
	logic [HTC_NTAP-1:0] rd_hit;

	// read mux; reserved and unmapped indices answer zero
	always_comb begin
		rd_hit     = tap_hit(reg_addr);
		rdata_next = HTC_RD_ZERO;
		rsvd_next  = rsvd_reg;
		if (reg_rd) begin
			for (int i = 0; i < HTC_NTAP; i++) begin
				if (rd_hit[i]) begin
					rdata_next = coef[i];
				end
			end
		end
		// sticky debug flag: host broke the reserved-space contract
		if (reg_wr && is_rsvd(reg_addr)) begin
			rsvd_next = 1'b1;
		end
		if (srst) begin
			rdata_next = HTC_RD_ZERO;
			rsvd_next  = 1'b0;
		end
	end

	always_ff @(posedge clk_sys) begin
		rdata_reg <= rdata_next;
		rsvd_reg  <= rsvd_next;
	end

	assign reg_rdata    = rdata_reg;
	assign rsvd_wr_seen = rsvd_reg;

	// ***********************************************************
	// assertions
	// ***********************************************************

	property p_wr_tap5;
		@(posedge clk_sys) disable iff (srst)
		(reg_wr && reg_addr == HTC_IDX_TAP5) |=>
			tap5_coefficient == $past(reg_wdata);
	endproperty
	a_wr_tap5: assert property (p_wr_tap5)
		else $error("tap5 write not stored");

	property p_wr_tap6;
		@(posedge clk_sys) disable iff (srst)
		(reg_wr && reg_addr == HTC_IDX_TAP6) |=>
			tap6_coefficient == $past(reg_wdata);
	endproperty
	a_wr_tap6: assert property (p_wr_tap6)
		else $error("tap6 write not stored");

	property p_wr_tap7;
		@(posedge clk_sys) disable iff (srst)
		(reg_wr && reg_addr == HTC_IDX_TAP7) |=>
			tap7_coefficient == $past(reg_wdata);
	endproperty
	a_wr_tap7: assert property (p_wr_tap7)
		else $error("tap7 write not stored");

	property p_wr_tap8;
		@(posedge clk_sys) disable iff (srst)
		(reg_wr && reg_addr == HTC_IDX_TAP8) |=>
			tap8_coefficient == $past(reg_wdata);
	endproperty
	a_wr_tap8: assert property (p_wr_tap8)
		else $error("tap8 write not stored");

	property p_rd_tap5;
		@(posedge clk_sys) disable iff (srst)
		(reg_rd && reg_addr == HTC_IDX_TAP5 && !reg_wr) |=>
			reg_rdata == tap5_coefficient;
	endproperty
	a_rd_tap5: assert property (p_rd_tap5)
		else $error("tap5 readback wrong");

	property p_rd_tap6;
		@(posedge clk_sys) disable iff (srst)
		(reg_rd && reg_addr == HTC_IDX_TAP6 && !reg_wr) |=>
			reg_rdata == tap6_coefficient;
	endproperty
	a_rd_tap6: assert property (p_rd_tap6)
		else $error("tap6 readback wrong");

	property p_rd_tap7;
		@(posedge clk_sys) disable iff (srst)
		(reg_rd && reg_addr == HTC_IDX_TAP7 && !reg_wr) |=>
			reg_rdata == tap7_coefficient;
	endproperty
	a_rd_tap7: assert property (p_rd_tap7)
		else $error("tap7 readback wrong");

	property p_rd_tap8;
		@(posedge clk_sys) disable iff (srst)
		(reg_rd && reg_addr == HTC_IDX_TAP8 && !reg_wr) |=>
			reg_rdata == tap8_coefficient;
	endproperty
	a_rd_tap8: assert property (p_rd_tap8)
		else $error("tap8 readback wrong");

	property p_reset_zero;
		@(posedge clk_sys)
		srst |=> (tap5_coefficient == HTC_COEF_RST)
			&& (tap8_coefficient == HTC_COEF_RST)
			&& (reg_rdata == HTC_RD_ZERO);
	endproperty
	a_reset_zero: assert property (p_reset_zero)
		else $error("registers not zero after reset");

	property p_zero_inert;
		@(posedge clk_sys) disable iff (srst)
		(tap6_coefficient == HTC_COEF_RST) |-> !tap6_active;
	endproperty
	a_zero_inert: assert property (p_zero_inert)
		else $error("zero tap6 still active");

	property p_hold;
		@(posedge clk_sys) disable iff (srst)
		(!reg_wr) |=> $stable(tap7_coefficient);
	endproperty
	a_hold: assert property (p_hold)
		else $error("tap7 changed without a write");

	property p_rsvd_no_effect;
		@(posedge clk_sys) disable iff (srst)
		(reg_wr && is_rsvd(reg_addr)) |=>
			$stable(tap5_coefficient) && $stable(tap8_coefficient)
			&& rsvd_wr_seen;
	endproperty
	a_rsvd_no_effect: assert property (p_rsvd_no_effect)
		else $error("reserved write disturbed taps");

	property p_rd_rsvd_zero;
		@(posedge clk_sys) disable iff (srst)
		(reg_rd && is_rsvd(reg_addr)) |=> reg_rdata == HTC_RD_ZERO;
	endproperty
	a_rd_rsvd_zero: assert property (p_rd_rsvd_zero)
		else $error("reserved read not zero");

	// read data stands one cycle only, then falls back to zero
	property p_rd_idle_zero;
		@(posedge clk_sys) disable iff (srst)
		(!reg_rd) |=> reg_rdata == HTC_RD_ZERO;
	endproperty
	a_rd_idle_zero: assert property (p_rd_idle_zero)
		else $error("read data stood without a read");

	// unmapped indices outside the taps must not alias onto them
	property p_rd_other_zero;
		@(posedge clk_sys) disable iff (srst)
		(reg_rd && tap_hit(reg_addr) == '0) |=> reg_rdata == HTC_RD_ZERO;
	endproperty
	a_rd_other_zero: assert property (p_rd_other_zero)
		else $error("unmapped read not zero");

	// the rest of the bank is cleared by the same reset
	property p_reset_rest;
		@(posedge clk_sys)
		srst |=> (tap6_coefficient == HTC_COEF_RST)
			&& (tap7_coefficient == HTC_COEF_RST)
			&& !tap5_active && !rsvd_wr_seen;
	endproperty
	a_reset_rest: assert property (p_reset_rest)
		else $error("bank not cleared by reset");

	// every stage enable tracks a nonzero coefficient
	property p_active_map;
		@(posedge clk_sys) disable iff (srst)
		(tap5_active == (tap5_coefficient != HTC_COEF_RST))
			&& (tap6_active == (tap6_coefficient != HTC_COEF_RST))
			&& (tap7_active == (tap7_coefficient != HTC_COEF_RST))
			&& (tap8_active == (tap8_coefficient != HTC_COEF_RST));
	endproperty
	a_active_map: assert property (p_active_map)
		else $error("stage enable disagrees with coefficient");

	// without a write no coefficient may drift
	property p_hold_rest;
		@(posedge clk_sys) disable iff (srst)
		(!reg_wr) |=> $stable(tap5_coefficient)
			&& $stable(tap6_coefficient) && $stable(tap8_coefficient);
	endproperty
	a_hold_rest: assert property (p_hold_rest)
		else $error("coefficient changed without a write");

	// the reserved-write flag is sticky until reset
	property p_rsvd_sticky;
		@(posedge clk_sys) disable iff (srst)
		rsvd_wr_seen |=> rsvd_wr_seen;
	endproperty
	a_rsvd_sticky: assert property (p_rsvd_sticky)
		else $error("reserved-write flag dropped");

	// and it rises only on a write into the reserved span
	property p_rsvd_only;
		@(posedge clk_sys) disable iff (srst)
		(!rsvd_wr_seen && !(reg_wr && is_rsvd(reg_addr))) |=>
			!rsvd_wr_seen;
	endproperty
	a_rsvd_only: assert property (p_rsvd_only)
		else $error("reserved-write flag rose without cause");

	c_wr_rd: cover property (@(posedge clk_sys) disable iff (srst)
		(reg_wr && reg_addr == HTC_IDX_TAP6) ##1
		(reg_rd && reg_addr == HTC_IDX_TAP6));
	c_rsvd: cover property (@(posedge clk_sys) disable iff (srst)
		reg_wr && is_rsvd(reg_addr));
	c_all_active: cover property (@(posedge clk_sys) disable iff (srst)
		tap5_active && tap6_active && tap7_active && tap8_active);
	c_rd_rsvd: cover property (@(posedge clk_sys) disable iff (srst)
		reg_rd && is_rsvd(reg_addr));
endmodule
`default_nettype wire

// ### htc_regs_tb.sv
// Purpose: self-checking bench for the hybrid tap 5..8 coefficient bank
// Assumes: index-addressed strobe bus, read data one cycle after strobe
// Notes:   a cycle monitor keeps a reference copy of the bank
`timescale 1ns/10ps
`default_nettype none
module htc_regs_tb
	import htc_pkg::*;
;
	logic              clk_sys, srst, reg_wr, reg_rd;
	logic [HTC_AW-1:0] reg_addr;
	logic [HTC_DW-1:0] reg_wdata, rd_exp, exp_d;
	wire  [HTC_DW-1:0] reg_rdata, t5, t6, t7, t8;
	logic [HTC_DW-1:0] m [HTC_NTAP];
	wire  [3:0]        act;
	wire               rsvd_wr_seen;
	logic              rd_d, chk_en, m_rsvd;
	int                n_errors = 0, n_compared = 0, cyc = 0;

	htc_regs i_htc_regs (.clk_sys(clk_sys), .srst(srst),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
		.reg_rd(reg_rd), .reg_rdata(reg_rdata), .tap5_coefficient(t5),
		.tap6_coefficient(t6), .tap7_coefficient(t7),
		.tap8_coefficient(t8), .tap5_active(act[0]),
		.tap6_active(act[1]), .tap7_active(act[2]),
		.tap8_active(act[3]), .rsvd_wr_seen(rsvd_wr_seen));

	// ****************************************
	// checking and closing
	// ****************************************
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp) begin
			n_errors++;
			$display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	task automatic end_of_test();
		$display("errors=%0d compared=%0d", n_errors, n_compared);
		if (n_errors == 0 && n_compared > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask

	// ****************************************
	// bus tasks, called right after an edge
	// ****************************************
	// strobes are left up so back-to-back calls never assign twice
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		reg_wr <= 1'b1;
		reg_rd <= 1'b0;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge clk_sys);
	endtask

	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		reg_rd <= 1'b1;
		reg_wr <= 1'b0;
		reg_addr <= a;
		rd_exp <= e;
		@(posedge clk_sys);
	endtask

	task automatic idle(input int n);
		reg_wr <= 1'b0;
		reg_rd <= 1'b0;
		repeat (n) @(posedge clk_sys);
	endtask

	// ****************************************
	// monitor: reference bank and timeout
	// ****************************************
	// sampled at the edge, so design outputs still hold last cycle's value
	always @(posedge clk_sys) begin
		cyc <= cyc + 1;
		if (cyc > 500) begin
			n_errors++;
			end_of_test();
		end
		if (chk_en) begin
			chk(reg_rdata, rd_d ? exp_d : HTC_RD_ZERO);
			chk({t8, t7, t6, t5}, {m[3], m[2], m[1], m[0]});
			chk(act, {|m[3], |m[2], |m[1], |m[0]});
			chk(rsvd_wr_seen, m_rsvd);
		end
		rd_d <= reg_rd & ~srst;
		exp_d <= rd_exp;
		if (srst) begin
			m <= '{default: HTC_COEF_RST};
			m_rsvd <= 1'b0;
		end else if (reg_wr) begin
			if (reg_addr >= HTC_IDX_TAP5 && reg_addr <= HTC_IDX_TAP8)
				m[2'(reg_addr - HTC_IDX_TAP5)] <= reg_wdata;
			if (reg_addr >= HTC_IDX_RSV_LO && reg_addr <= HTC_IDX_RSV_HI)
				m_rsvd <= 1'b1;
		end
	end

	initial begin
		clk_sys = 1'b0;
		forever #10 clk_sys = ~clk_sys;
	end

	// ****************************************
	// test sequence
	// ****************************************
	initial begin
		{srst, reg_wr, reg_rd, chk_en} = 4'b1000;
		{reg_addr, reg_wdata, rd_exp} = '0;
		repeat (6) @(posedge clk_sys);
		srst <= 1'b0;
		chk_en <= 1'b1;
		for (int i = 0; i < 4; i++) rd(HTC_IDX_TAP5 + 8'(i), 8'h00);
		wr(HTC_IDX_TAP5, 8'hA5);
		wr(HTC_IDX_TAP6, 8'h5A);
		wr(HTC_IDX_TAP7, 8'h01);
		wr(HTC_IDX_TAP8, 8'hFF);
		rd(HTC_IDX_TAP5, 8'hA5);
		rd(HTC_IDX_TAP6, 8'h5A);
		rd(HTC_IDX_TAP7, 8'h01);
		rd(HTC_IDX_TAP8, 8'hFF);
		wr(HTC_IDX_TAP5, 8'h80);
		rd(HTC_IDX_TAP5, 8'h80);
		wr(HTC_IDX_TAP6, 8'h00);
		rd(HTC_IDX_TAP6, 8'h00);
		idle(2);
		// unmapped neighbours must not alias onto the taps
		wr(8'h30, 8'h11);
		wr(8'h3B, 8'h22);
		wr(HTC_IDX_RSV_LO, 8'h33);
		wr(HTC_IDX_RSV_HI, 8'h44);
		rd(8'h30, 8'h00);
		rd(HTC_IDX_RSV_LO, 8'h00);
		rd(HTC_IDX_RSV_HI, 8'h00);
		rd(8'h3B, 8'h00);
		rd(HTC_IDX_TAP6, 8'h00);
		idle(2);
		// second reset mid-run with nonzero taps
		srst <= 1'b1;
		repeat (6) @(posedge clk_sys);
		srst <= 1'b0;
		for (int i = 0; i < 4; i++) rd(HTC_IDX_TAP5 + 8'(i), 8'h00);
		idle(3);
		end_of_test();
	end
endmodule
`default_nettype wire
